// ==== hdl/uart_mp_port.v ====
// four-mode serial port with frame-error detection and address filtering
`include "uart_mp_map.vh"

// Behaviour
// - mode 2 frame: start, 8 data, ninth, stop
// - ninth bit sent from, received into register
// - mode 2 rate osc/64, or osc/32 doubled
// - mode 3 like mode 2, timer rate
// - any buffer write starts transmission
// - mode 0 receive when done clear, enabled
// - modes 1-3 receive on falling start edge
// - two mode bits select one of four modes
// - frame error sticky, cleared only by software
// - control bit 7 is error or mode bit
// - mode 1 filter: valid stop and match
// - receive enable resets to off
// - transmit done flag set at end
// - receive done flag set at end, filtered
// - address and mask registers read-write
// - filtering ignored in mode 0
// - separate transmit and receive buffers
// - mode 0 shift with clock, osc/12 or /2
// - mode 1 frame 10 bits, stop kept
// - interrupt request is OR of done flags
module uart_mp_port (
	input wire clock, // 250 MHz oscillator
	input wire rst, // async reset, active high
	input wire [2:0] regAddr, // register index
	input wire [7:0] regWrData, // write data
	input wire regWr, // write strobe
	input wire regRd, // read strobe
	output reg [7:0] regRdData_ff, // read data, cycle after strobe
	input wire t1Ovf, // timer-1 overflow pulse
	input wire rxdIn, // serial input pin level
	output reg rxdOut_ff, // serial pin drive value (mode 0)
	output reg rxdOe_ff, // serial pin output enable
	output reg txdPin_ff, // transmit pin or shift clock
	output reg serialIrq_ff // serial interrupt request
);
	reg modeHi_ff, modeLo_ff, mprocEn_ff, rxEn_ff, txNinth_ff, rxNinth_ff;
	reg txDone_ff, rxDone_ff, frameErr_ff;
	reg baudDbl_ff, feSel_ff, m0Fast_ff;
	reg [7:0] slaveAddr_ff, slaveMask_ff, txBuf_ff, rxBuf_ff;

	reg m0Busy_ff, m0Rx_ff;
	reg [3:0] m0Cnt_ff;
	reg [7:0] m0Sh_ff;

	reg txBusy_ff;
	reg [3:0] txSub_ff, txCnt_ff;
	reg [10:0] txSh_ff;

	reg rxBusy_ff, rxPrev_ff;
	reg [3:0] rxSub_ff, rxBit_ff;
	reg [9:0] rxSh_ff;

	wire [1:0] mode = {modeHi_ff, modeLo_ff};
	wire wrCtrl = regWr && regAddr == `OFF_SERIAL_CONTROL;
	wire wrBuf = regWr && regAddr == `OFF_SERIAL_BUFFER;
	wire m0Tick, ovsTick;
	wire m0Start = (mode == `MODE_SHIFT) && (wrBuf || (!m0Busy_ff && !rxDone_ff && rxEn_ff));

	// both rate dividers share one module: half bits in mode 0, 16x oversample otherwise
	pulse_divider #(.W(4)) m0Div (
		.clock(clock),
		.rst(rst),
		.clr(m0Start),
		.srcPulse(1'b1),
		.div(m0Fast_ff ? `M0_HALF_FAST : `M0_HALF_SLOW),
		.tick_ff(m0Tick)
	);

	pulse_divider #(.W(4)) ovsDiv (
		.clock(clock),
		.rst(rst),
		.clr(1'b0),
		.srcPulse(mode == `MODE_UART9_FIX ? 1'b1 : t1Ovf),
		.div(mode == `MODE_UART9_FIX ? (baudDbl_ff ? `M2_TICK_FAST : `M2_TICK_SLOW)
			: (baudDbl_ff ? `T1_TICK_FAST : `T1_TICK_SLOW)),
		.tick_ff(ovsTick)
	);

	// receive frame decoding, combinational
	reg rxFinish, rxAbort;
	reg [9:0] rxVec;
	reg [7:0] rxByte;
	reg rxNinthNew, rxStop, addrHit, rxAccept;
	wire [7:0] bcast = slaveAddr_ff | slaveMask_ff;
	always @* begin
		rxFinish = 1'b0;
		rxAbort = 1'b0;
		rxVec = {rxdIn, rxSh_ff[9:1]};
		if (rxBusy_ff && ovsTick && rxSub_ff == `OVS_MID) begin
			if (rxBit_ff == 4'h0)
				rxAbort = rxdIn;
			else if (mode == `MODE_UART8)
				rxFinish = rxBit_ff == `BITS_AFTER_START_M1;
			else
				rxFinish = rxBit_ff == `BITS_AFTER_START_M23;
		end
		if (mode == `MODE_UART8) begin
			rxByte = rxVec[8:1];
			rxNinthNew = rxVec[9];
		end else begin
			rxByte = rxVec[7:0];
			rxNinthNew = rxVec[8];
		end
		rxStop = rxVec[9];
		// masked given address, or broadcast with zero bits as don't care
		addrHit = (((rxByte ^ slaveAddr_ff) & slaveMask_ff) == 8'h00)
			|| (((rxByte ^ bcast) & bcast) == 8'h00);
		if (!mprocEn_ff)
			rxAccept = 1'b1;
		else if (mode == `MODE_UART8)
			rxAccept = rxStop && addrHit;
		else
			rxAccept = rxNinthNew && addrHit;
	end

	wire m0End = m0Busy_ff && m0Tick && m0Cnt_ff == `M0_LAST_HALF;
	wire txEnd = txBusy_ff && ovsTick && txSub_ff == `OVS_LAST
		&& txCnt_ff == (mode == `MODE_UART8 ? `TX_BITS_M1 : `TX_BITS_M23) - 4'h1;
	wire txEvt = txEnd || (m0End && !m0Rx_ff);
	wire rxEvt = (rxFinish && rxAccept) || (m0End && m0Rx_ff);

	// register file; a hardware set wins over a software clear in the same cycle
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			modeHi_ff <= 1'b0;
			modeLo_ff <= 1'b0;
			mprocEn_ff <= 1'b0;
			rxEn_ff <= 1'b0;
			txNinth_ff <= 1'b0;
			rxNinth_ff <= 1'b0;
			txDone_ff <= 1'b0;
			rxDone_ff <= 1'b0;
			frameErr_ff <= 1'b0;
			baudDbl_ff <= 1'b0;
			feSel_ff <= 1'b0;
			m0Fast_ff <= 1'b0;
			slaveAddr_ff <= `RST_BYTE;
			slaveMask_ff <= `RST_BYTE;
			txBuf_ff <= `RST_BYTE;
			rxBuf_ff <= `RST_BYTE;
		end else begin
			if (wrCtrl) begin
				if (feSel_ff)
					frameErr_ff <= regWrData[`SC_MODE_HI] || (rxFinish && !rxStop);
				else
					modeHi_ff <= regWrData[`SC_MODE_HI];
				modeLo_ff <= regWrData[`SC_MODE_LO];
				mprocEn_ff <= regWrData[`SC_MPROC_EN];
				rxEn_ff <= regWrData[`SC_RX_EN];
				txNinth_ff <= regWrData[`SC_TX_NINTH];
			end
			if (!(wrCtrl && feSel_ff) && rxFinish && !rxStop)
				frameErr_ff <= 1'b1;
			if (rxFinish && rxAccept)
				rxNinth_ff <= rxNinthNew;
			else if (wrCtrl)
				rxNinth_ff <= regWrData[`SC_RX_NINTH];
			txDone_ff <= txEvt || (wrCtrl ? regWrData[`SC_TX_DONE] : txDone_ff);
			rxDone_ff <= rxEvt || (wrCtrl ? regWrData[`SC_RX_DONE] : rxDone_ff);
			if (rxEvt)
				rxBuf_ff <= m0Rx_ff && m0End ? {rxdIn, m0Sh_ff[7:1]} : rxByte;
			if (wrBuf)
				txBuf_ff <= regWrData;
			if (regWr && regAddr == `OFF_POWER_CONTROL) begin
				baudDbl_ff <= regWrData[`PC_BAUD_DBL];
				feSel_ff <= regWrData[`PC_FE_SEL];
			end
			if (regWr && regAddr == `OFF_SLAVE_ADDRESS)
				slaveAddr_ff <= regWrData;
			if (regWr && regAddr == `OFF_SLAVE_ADDRESS_MASK)
				slaveMask_ff <= regWrData;
			if (regWr && regAddr == `OFF_AUX_CONTROL)
				m0Fast_ff <= regWrData[`AUX_M0_FAST];
		end
	end

	// read port: data only in the cycle after the strobe, zero otherwise
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdData_ff <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
			`OFF_SERIAL_CONTROL: regRdData_ff <= {feSel_ff ? frameErr_ff : modeHi_ff,
				modeLo_ff, mprocEn_ff, rxEn_ff, txNinth_ff, rxNinth_ff, txDone_ff, rxDone_ff};
			`OFF_SERIAL_BUFFER: regRdData_ff <= rxBuf_ff;
			`OFF_POWER_CONTROL: regRdData_ff <= {baudDbl_ff, feSel_ff, 6'h00};
			`OFF_SLAVE_ADDRESS: regRdData_ff <= slaveAddr_ff;
			`OFF_SLAVE_ADDRESS_MASK: regRdData_ff <= slaveMask_ff;
			`OFF_AUX_CONTROL: regRdData_ff <= {2'h0, m0Fast_ff, 5'h00};
			default: regRdData_ff <= 8'h00;
			endcase
		end else begin
			regRdData_ff <= 8'h00;
		end
	end

	// mode 0 engine: even half periods drive clock low, odd ones high;
	// data moves at the end of each high half, so the partner sees a full high phase
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			m0Busy_ff <= 1'b0;
			m0Rx_ff <= 1'b0;
			m0Cnt_ff <= 4'h0;
			m0Sh_ff <= 8'hFF;
		end else if (m0Start) begin
			m0Busy_ff <= 1'b1;
			m0Rx_ff <= !wrBuf;
			m0Cnt_ff <= 4'h0;
			m0Sh_ff <= wrBuf ? regWrData : 8'hFF;
		end else if (mode != `MODE_SHIFT) begin
			m0Busy_ff <= 1'b0;
		end else if (m0Busy_ff && m0Tick) begin
			m0Cnt_ff <= m0Cnt_ff + 4'h1;
			if (m0Cnt_ff[0])
				m0Sh_ff <= {m0Rx_ff ? rxdIn : 1'b1, m0Sh_ff[7:1]};
			if (m0End)
				m0Busy_ff <= 1'b0;
		end
	end

	// framed transmitter, LSB first after the start bit
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			txBusy_ff <= 1'b0;
			txSub_ff <= 4'h0;
			txCnt_ff <= 4'h0;
			txSh_ff <= 11'h7FF;
		end else if (wrBuf && mode != `MODE_SHIFT) begin
			txBusy_ff <= 1'b1;
			txSub_ff <= 4'h0;
			txCnt_ff <= 4'h0;
			if (mode == `MODE_UART8)
				txSh_ff <= {2'h3, regWrData, 1'b0};
			else
				txSh_ff <= {1'b1, txNinth_ff, regWrData, 1'b0};
		end else if (mode == `MODE_SHIFT) begin
			txBusy_ff <= 1'b0;
		end else if (txBusy_ff && ovsTick) begin
			txSub_ff <= txSub_ff + 4'h1;
			if (txSub_ff == `OVS_LAST) begin
				txSh_ff <= {1'b1, txSh_ff[10:1]};
				txCnt_ff <= txCnt_ff + 4'h1;
				if (txEnd)
					txBusy_ff <= 1'b0;
			end
		end
	end

	// framed receiver: 16x oversampling, each bit taken at its middle tick
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rxBusy_ff <= 1'b0;
			rxPrev_ff <= 1'b1;
			rxSub_ff <= 4'h0;
			rxBit_ff <= 4'h0;
			rxSh_ff <= 10'h000;
		end else begin
			rxPrev_ff <= rxdIn;
			if (mode == `MODE_SHIFT || !rxEn_ff) begin
				rxBusy_ff <= 1'b0;
			end else if (!rxBusy_ff) begin
				if (rxPrev_ff && !rxdIn) begin
					rxBusy_ff <= 1'b1;
					rxSub_ff <= 4'h0;
					rxBit_ff <= 4'h0;
				end
			end else if (ovsTick) begin
				rxSub_ff <= rxSub_ff + 4'h1;
				if (rxSub_ff == `OVS_MID) begin
					rxBit_ff <= rxBit_ff + 4'h1;
					if (rxBit_ff != 4'h0)
						rxSh_ff <= rxVec;
					if (rxAbort || rxFinish)
						rxBusy_ff <= 1'b0;
				end
			end
		end
	end

	// pins: txd carries the shift clock in mode 0, the frame otherwise
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			txdPin_ff <= 1'b1;
			rxdOut_ff <= 1'b1;
			rxdOe_ff <= 1'b0;
			serialIrq_ff <= 1'b0;
		end else begin
			if (mode == `MODE_SHIFT)
				txdPin_ff <= !m0Busy_ff || m0Cnt_ff[0];
			else
				txdPin_ff <= !txBusy_ff || txSh_ff[0];
			rxdOut_ff <= m0Sh_ff[0];
			rxdOe_ff <= mode == `MODE_SHIFT && m0Busy_ff && !m0Rx_ff;
			serialIrq_ff <= txDone_ff || rxDone_ff;
		end
	end
endmodule

// ==== hdl/uart_mp_map.vh ====
// register map, field positions, reset values and rate divisors of the serial port
`ifndef UART_MP_MAP_VH
`define UART_MP_MAP_VH

`define OFF_SERIAL_CONTROL 3'h0
`define OFF_SERIAL_BUFFER 3'h1
`define OFF_POWER_CONTROL 3'h2
`define OFF_SLAVE_ADDRESS 3'h3
`define OFF_SLAVE_ADDRESS_MASK 3'h4
`define OFF_AUX_CONTROL 3'h5

// serial_control fields
`define SC_MODE_HI 7
`define SC_MODE_LO 6
`define SC_MPROC_EN 5
`define SC_RX_EN 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_DONE 1
`define SC_RX_DONE 0

// power_control_reg and aux fields
`define PC_BAUD_DBL 7
`define PC_FE_SEL 6
`define AUX_M0_FAST 5

`define RST_BYTE 8'h00

`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9_FIX 2'h2
`define MODE_UART9_VAR 2'h3

// clocks per mode-0 half bit: 12 or 2 clocks per bit
`define M0_HALF_SLOW 4'h6
`define M0_HALF_FAST 4'h1
// clocks per oversample tick in mode 2: 64 or 32 clocks per bit over 16 ticks
`define M2_TICK_SLOW 4'h4
`define M2_TICK_FAST 4'h2
// timer overflows per oversample tick in modes 1 and 3
`define T1_TICK_SLOW 4'h2
`define T1_TICK_FAST 4'h1

`define OVS_MID 4'h7
`define OVS_LAST 4'hF
`define M0_LAST_HALF 4'hF
`define BITS_AFTER_START_M1 4'h9
`define BITS_AFTER_START_M23 4'hA
`define TX_BITS_M1 4'hA
`define TX_BITS_M23 4'hB

`endif

// ==== hdl/pulse_divider.v ====
// divides a pulse stream by a run-time ratio, emitting one-cycle ticks
module pulse_divider #(
	parameter W = 4
) (
	input wire clock, // system clock
	input wire rst, // async reset, active high
	input wire clr, // restart the count
	input wire srcPulse, // pulse to be divided
	input wire [W-1:0] div, // ratio, at least 1
	output reg tick_ff // one-cycle output tick
);
	reg [W-1:0] cnt_ff;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_ff <= {W{1'b0}};
			tick_ff <= 1'b0;
		end else if (clr) begin
			// the clearing cycle counts as the first pulse, so the first period is not one longer
			if (div <= {{(W-1){1'b0}}, 1'b1}) begin
				cnt_ff <= {W{1'b0}};
				tick_ff <= 1'b1;
			end else begin
				cnt_ff <= {{(W-1){1'b0}}, 1'b1};
				tick_ff <= 1'b0;
			end
		end else if (srcPulse) begin
			if (cnt_ff >= div - {{(W-1){1'b0}}, 1'b1}) begin
				cnt_ff <= {W{1'b0}};
				tick_ff <= 1'b1;
			end else begin
				cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
				tick_ff <= 1'b0;
			end
		end else begin
			tick_ff <= 1'b0;
		end
	end
endmodule

// ==== sim/uart_mp_port_chk.sv ====
// port-level assertions for the serial port
module uart_mp_port_chk (
	input wire clock, // system clock
	input wire rst, // async reset
	input wire [2:0] regAddr, // register index
	input wire [7:0] regWrData, // write data
	input wire regWr, // write strobe
	input wire regRd, // read strobe
	input wire [7:0] regRdData_ff, // read data
	input wire rxdOe_ff, // serial pin enable
	input wire txdPin_ff, // transmit line or shift clock
	input wire serialIrq_ff // interrupt request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mode_ff;
	logic feSel_ff;
	logic fast_ff;
	// shadow of the mode bits; bit 7 only reaches the mode while it is not the error flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_ff <= 2'h0;
			feSel_ff <= 1'b0;
			fast_ff <= 1'b0;
		end else if (regWr) begin
			if (regAddr == 3'h0 && !feSel_ff) mode_ff[1] <= regWrData[7];
			if (regAddr == 3'h0) mode_ff[0] <= regWrData[6];
			if (regAddr == 3'h2) feSel_ff <= regWrData[6];
			if (regAddr == 3'h5) fast_ff <= regWrData[5];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence lowHalf;
		!txdPin_ff [*6];
	endsequence
	reset_idle_a: assert property ($fell(rst) |-> txdPin_ff && !rxdOe_ff)
		else $error("outputs not idle after reset");
	read_idle_a: assert property (!$past(regRd) |-> regRdData_ff == 8'h00)
		else $error("read data outside the answer cycle");
	irq_flag_a: assert property (regWr && regAddr == 3'h0 && regWrData[1] |-> ##[1:2] serialIrq_ff)
		else $error("done flag without interrupt request");
	tx_start_a: assert property (regWr && regAddr == 3'h1 |-> ##[1:3] !txdPin_ff)
		else $error("buffer write did not start a transfer");
	oe_mode_a: assert property (rxdOe_ff |-> mode_ff == 2'h0)
		else $error("pin driven outside shift mode");
	first_low_a: assert property ($rose(rxdOe_ff) |-> !txdPin_ff)
		else $error("shift clock not low at start");
	shift_half_a: assert property (mode_ff == 2'h0 && !fast_ff && $fell(txdPin_ff) |->
		lowHalf ##1 txdPin_ff)
		else $error("shift clock half period wrong");
	fast_half_a: assert property (mode_ff == 2'h0 && fast_ff && $fell(txdPin_ff) |->
		##1 txdPin_ff)
		else $error("fast shift clock half period wrong");
	start_bit_a: assert property (mode_ff != 2'h0 && $fell(txdPin_ff) |-> !txdPin_ff [*8])
		else $error("framed bit too short");
endmodule

bind uart_mp_port uart_mp_port_chk uart_mp_port_chk_i (.clock(clock), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
	.rxdOe_ff(rxdOe_ff), .txdPin_ff(txdPin_ff), .serialIrq_ff(serialIrq_ff));

// ==== sim/remote_node.sv ====
// remote serial node: sends frames to the port and samples frames from it
module remote_node (
	input wire clock, // system clock
	input wire txdLine, // port transmit line
	output logic rxdLine // port receive line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxdLine = 1'b1;
	// start low, data LSB first, ninth only when n is 11, stop; line back high afterwards
	task automatic send(input logic [8:0] d, input logic stopBit, input int per, input int n);
		logic [10:0] f;
		f = (n == 10) ? {2'b11, d[7:0], 1'b0} : {stopBit, d, 1'b0};
		if (n == 10) f[9] = stopBit;
		for (int i = 0; i < n; i++) begin
			rxdLine <= f[i];
			repeat (per) @(posedge clock);
		end
		rxdLine <= 1'b1;
	endtask
	// samples each bit in its middle; unused top bits stay 1
	task automatic recv(input int per, input int n, output logic [10:0] f);
		f = 11'h7FF;
		@(negedge txdLine);
		repeat (per / 2) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			f[i] = txdLine;
			repeat (per) @(posedge clock);
		end
	endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the serial port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, regWr = 0, regRd = 0, t1Ovf = 0, m0Sel = 0, m0Bit = 1;
	logic [2:0] regAddr = 0;
	logic [7:0] regWrData = 0;
	logic [7:0] rd;
	logic [10:0] fr;
	localparam logic [7:0] M0RX = 8'h3C;
	// {enable, ninth, accepted, byte}
	logic [10:0] rxCases [5] = '{11'h25A, 11'h75A, 11'h45A, 11'h633, 11'h7FF};
	int bad_count = 0, check_count = 0;
	wire [7:0] regRdData_ff;
	wire rxdOut_ff, rxdOe_ff, txdPin_ff, serialIrq_ff, nodeRxd;
	wire pinLevel = rxdOe_ff ? rxdOut_ff : (m0Sel ? m0Bit : nodeRxd);
	always #2 clock = ~clock;
	always @(posedge clock) t1Ovf <= ~t1Ovf;
	uart_mp_port uart_mp_port_i (.clock(clock), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
		.t1Ovf(t1Ovf), .rxdIn(pinLevel), .rxdOut_ff(rxdOut_ff), .rxdOe_ff(rxdOe_ff),
		.txdPin_ff(txdPin_ff), .serialIrq_ff(serialIrq_ff));
	remote_node remote_node_i (.clock(clock), .txdLine(txdPin_ff), .rxdLine(nodeRxd));
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		@(negedge clock);
		check({3'h0, regRdData_ff & m}, {3'h0, exp});
		@(posedge clock);
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rdc(3'h0, 8'hFF, 8'h00);
		wr(3'h3, 8'h5A);
		wr(3'h4, 8'hFF);
		rdc(3'h3, 8'hFF, 8'h5A);
		rdc(3'h4, 8'hFF, 8'hFF);
		rdc(3'h6, 8'hFF, 8'h00);
		fork
			wr(3'h1, 8'hA5);
			for (int i = 0; i < 8; i++) begin
				@(posedge txdPin_ff);
				rd[i] = rxdOut_ff;
			end
		join
		check({3'h0, rd}, 11'h0A5);
		for (int i = 0; i < 200 && serialIrq_ff !== 1'b1; i++) @(posedge clock);
		rdc(3'h0, 8'h03, 8'h02);
		check({10'h0, serialIrq_ff}, 11'h001);
		m0Sel <= 1'b1;
		// filter enabled here too: shift mode must ignore it
		fork
			wr(3'h0, 8'h30);
			for (int i = 0; i < 8; i++) begin
				@(negedge txdPin_ff);
				m0Bit <= M0RX[i];
			end
		join
		for (int i = 0; i < 200 && serialIrq_ff !== 1'b1; i++) @(posedge clock);
		rdc(3'h0, 8'h01, 8'h01);
		rdc(3'h1, 8'hFF, M0RX);
		wr(3'h0, 8'h00);
		wr(3'h5, 8'h20);
		rdc(3'h5, 8'hFF, 8'h20);
		fork
			wr(3'h1, 8'h96);
			for (int i = 0; i < 8; i++) begin
				@(posedge txdPin_ff);
				rd[i] = rxdOut_ff;
			end
		join
		check({3'h0, rd}, 11'h096);
		m0Sel <= 1'b0;
		for (int m = 1; m < 4; m++) begin
			for (int d = 0; d < 2; d++) begin
				wr(3'h2, {d[0], 7'h00});
				wr(3'h0, {m[1:0], 2'h0, d[0], 3'h0});
				fork
					remote_node_i.recv(64 >> d, (m > 1) ? 11 : 10, fr);
					wr(3'h1, 8'hC6);
				join
				check(fr, (m == 1) ? 11'h78C : {1'b1, d[0], 9'h18C});
			end
		end
		foreach (rxCases[k]) begin
			wr(3'h0, {3'b101, rxCases[k][10], 4'h0});
			remote_node_i.send({rxCases[k][9], rxCases[k][7:0]}, 1'b1, 32, 11);
			repeat (4) @(posedge clock);
			rdc(3'h0, 8'h05, {5'h0, rxCases[k][9] & rxCases[k][8], 1'b0, rxCases[k][8]});
			if (rxCases[k][8]) rdc(3'h1, 8'hFF, rxCases[k][7:0]);
		end
		wr(3'h2, 8'h80);
		wr(3'h0, 8'h70);
		wr(3'h2, 8'hC0);
		remote_node_i.send(9'h05A, 1'b0, 32, 10);
		rdc(3'h0, 8'h81, 8'h80);
		remote_node_i.send(9'h05A, 1'b1, 32, 10);
		rdc(3'h0, 8'h85, 8'h85);
		wr(3'h0, 8'h70);
		rdc(3'h0, 8'h81, 8'h00);
		check({10'h0, serialIrq_ff}, 11'h000);
		wr(3'h2, 8'h80);
		rdc(3'h0, 8'hC0, 8'h40);
		wr(3'h0, 8'h42);
		rdc(3'h0, 8'hC3, 8'h42);
		check({10'h0, serialIrq_ff}, 11'h001);
		wrap_up();
	end
endmodule
